// File: src/tsf_frame_builder.sv
// Design decisions made here: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Beacon frame has identifier zero and a 69-byte value block.
// - Bytes 3-18 carry message bits 17-144; short message ends in ones.
// - Bytes 19-26 carry the hex identifier right aligned, top nibble zero.
// - Bytes 27-32 first detection date and time, 0xFF when out of range.
// - Bytes 33-38 last detection date and time, same layout and codes.
// - Bytes 39-42 beacon latitude as a 32-bit float.
// - Bytes 43-46 beacon longitude as a 32-bit float.
// - Bytes 47-48 signed frequency offset, limited to -30000..31000 Hz.
// - Byte 49 is dBm plus 150, 255 when invalid.
// - Bytes 50-51 message counter, all ones means invalid.
// - Bearing and course 0..3599, distance 0..9999, else 0xFFFF.
// - Bytes 58-60 elapsed time hours, minutes, seconds, 0xFF invalid.
// - Bytes 61-63 arrival time hours, minutes, seconds, 0xFF invalid.
// - Bytes 64-65 country code 0..999, else all ones.
// - Byte 66 high nibble beacon category, unused codes become 15.
// - Byte 66 low nibble protocol, unused codes become 15.
// - Bytes 67-68 serial number 1..16383, else all ones.
// - Waypoint frame has identifier one, 53 bytes, index and count first.
// - Waypoint status byte: bits 7-2 zero, unit bit, position valid bit.
// - Name and info text restricted to allowed characters, zero padded.
// - Waypoint position floats then bearing, distance, course as beacon.
// - Waypoint elapsed and arrival times, 0xFF invalid.
// - Every multi-byte field leaves most significant byte first.
// - Beacon status bit 1 selects kilometres or nautical miles.
// - A zero total count leaves every other byte without meaning.
module tsf_frame_builder
  import tsf_pkg::*;
(
  // Clock and reset
  input  wire logic          ref_clk_i,
  input  wire logic          resetn_i,
  // Register port
  input  wire logic [7:0]    reg_addr_i,
  input  wire logic [31:0]   reg_wdata_i,
  input  wire logic          reg_we_i,
  input  wire logic          reg_re_i,
  output logic      [31:0]   reg_rdata_o,
  // Target records
  input  wire tsf_beacon_t   beacon_i,
  input  wire tsf_waypoint_t waypoint_i,
  // Byte stream towards the packet layer
  output logic               tx_valid_o,
  input  wire logic          tx_ready_i,
  output tsf_byte_t          tx_o
);

  //////////////////////////////////////////////////////////////////////////////
  // Field conditioning helpers

  // Byte field within a range, otherwise the invalid code
  function automatic logic [7:0] rng8(input logic [7:0] v, input logic [7:0] lo,
                                      input logic [7:0] hi);
    rng8 = (v >= lo && v <= hi) ? v : TSF_INV8;
  endfunction

  // Word field within a range, otherwise the invalid code
  function automatic logic [15:0] rng16(input logic [15:0] v, input logic [15:0] lo,
                                        input logic [15:0] hi);
    rng16 = (v >= lo && v <= hi) ? v : TSF_INV16;
  endfunction

  // Calendar date and time; UTC offset is already applied by the source
  function automatic tsf_date_t date_fix(input tsf_date_t d);
    tsf_date_t r;
    r.year   = rng8(d.year,   8'h00, 8'h63);
    r.month  = rng8(d.month,  8'h01, 8'h0C);
    r.day    = rng8(d.day,    8'h01, 8'h1F);
    r.hour   = rng8(d.hour,   8'h00, 8'h17);
    r.minute = rng8(d.minute, 8'h00, 8'h3B);
    r.second = rng8(d.second, 8'h00, 8'h3B);
    date_fix = r;
  endfunction

  // Hours, minutes, seconds
  function automatic tsf_hms_t hms_fix(input tsf_hms_t t);
    tsf_hms_t r;
    r.hour   = rng8(t.hour,   8'h00, 8'h17);
    r.minute = rng8(t.minute, 8'h00, 8'h3B);
    r.second = rng8(t.second, 8'h00, 8'h3B);
    hms_fix = r;
  endfunction

  // Text byte: disallowed characters become a space so alignment holds
  function automatic logic [7:0] txt_fix(input logic [7:0] c);
    logic ok;
    ok = (c == 8'h00) || (c == 8'h20) || (c >= 8'h2D && c <= 8'h39) ||
         (c >= 8'h41 && c <= 8'h5A);
    txt_fix = ok ? c : 8'h20;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Beacon value block assembly

  wire logic [127:0] bc_msg = beacon_i.short_msg ?
                              {beacon_i.message[127:32], TSF_SHORT_FILL} : beacon_i.message;

  wire logic [63:0]  bc_hex = {4'h0, beacon_i.beacon_hex_identifier};

  wire logic [7:0]   bc_status = {2'b00, beacon_i.self_test, beacon_i.manual_offset,
                                  beacon_i.auto_offset, beacon_i.pdf2_valid,
                                  beacon_i.dist_nm, beacon_i.pos_valid};

  wire tsf_date_t    bc_first = date_fix(beacon_i.first_seen);
  wire tsf_date_t    bc_last  = date_fix(beacon_i.last_seen);

  wire logic signed [15:0] bc_freq = (beacon_i.freq_offset < TSF_FREQ_MIN) ? TSF_FREQ_MIN :
                                     (beacon_i.freq_offset > TSF_FREQ_MAX) ? TSF_FREQ_MAX :
                                     beacon_i.freq_offset;

  wire logic         bc_dbm_ok  = beacon_i.dbm_valid && (beacon_i.dbm >= TSF_DBM_MIN) &&
                                  (beacon_i.dbm <= TSF_DBM_MAX);
  wire logic [15:0]  bc_dbm_sum = beacon_i.dbm + TSF_DBM_BIAS;
  wire logic [7:0]   bc_dbm     = bc_dbm_ok ? bc_dbm_sum[7:0] : TSF_INV8;

  wire logic [15:0]  bc_bear = rng16(beacon_i.bearing, 16'h0000, TSF_ANGLE_MAX);
  wire logic [15:0]  bc_dist = rng16(beacon_i.distance, 16'h0000, TSF_DIST_MAX);
  wire logic [15:0]  bc_cdev = rng16(beacon_i.course_deviation, 16'h0000, TSF_ANGLE_MAX);

  wire tsf_hms_t     bc_eet = hms_fix(beacon_i.elapsed_time_to_target);
  wire tsf_hms_t     bc_eta = hms_fix(beacon_i.arrival_time_at_target);

  wire logic [15:0]  bc_ctry   = rng16(beacon_i.country, 16'h0000, TSF_COUNTRY_MAX);
  wire logic [15:0]  bc_serial = rng16(beacon_i.serial, 16'h0001, TSF_SERIAL_MAX);

  wire logic [3:0]   bc_cat   = (beacon_i.category <= TSF_CAT_LAST) ? beacon_i.category
                                                                    : TSF_INV4;
  wire logic [3:0]   bc_proto = (beacon_i.protocol <= TSF_PROTO_LAST) ? beacon_i.protocol
                                                                      : TSF_INV4;

  // byte 0 at the top, fields most significant byte first
  wire logic [TSF_MAX_BITS-25:0] bc_body = {
    bc_msg, bc_hex, bc_first, bc_last,
    beacon_i.latitude,
    beacon_i.longitude,
    bc_freq, bc_dbm,
    beacon_i.msg_counter,
    bc_bear, bc_dist, bc_cdev, bc_eet, bc_eta, bc_ctry,
    bc_cat, bc_proto, bc_serial
  };

  // empty database clears everything after the count
  wire logic         bc_empty = (beacon_i.count == 8'h00);
  wire logic [TSF_MAX_BITS-1:0] bc_block = bc_empty ?
    {beacon_i.index, 8'h00, {(TSF_MAX_BITS-16){1'b0}}} :
    {beacon_i.index, beacon_i.count, bc_status, bc_body};

  //////////////////////////////////////////////////////////////////////////////
  // Waypoint value block assembly

  // status byte, upper bits held at zero
  wire logic [7:0]   wp_status = {6'b000000, waypoint_i.dist_nm, waypoint_i.pos_valid};

  // text filtering, one byte lane per character
  logic [79:0]       wp_name;
  logic [159:0]      wp_info;
  for (genvar g = 0; g < 10; g++)
  begin : g_name
    assign wp_name[g*8 +: 8] = txt_fix(waypoint_i.name[g*8 +: 8]);
  end
  for (genvar g = 0; g < 20; g++)
  begin : g_info
    assign wp_info[g*8 +: 8] = txt_fix(waypoint_i.info[g*8 +: 8]);
  end

  // navigation fields with beacon units and codes
  wire logic [15:0]  wp_bear = rng16(waypoint_i.bearing, 16'h0000, TSF_ANGLE_MAX);
  wire logic [15:0]  wp_dist = rng16(waypoint_i.distance, 16'h0000, TSF_DIST_MAX);
  wire logic [15:0]  wp_cdev = rng16(waypoint_i.course_deviation, 16'h0000, TSF_ANGLE_MAX);

  wire tsf_hms_t     wp_eet = hms_fix(waypoint_i.elapsed_time_to_target);
  wire tsf_hms_t     wp_eta = hms_fix(waypoint_i.arrival_time_at_target);

  // waypoint block, left justified in the shared shifter
  wire logic         wp_empty = (waypoint_i.count == 8'h00);
  wire logic [TSF_WP_BITS-1:0] wp_full = {
    waypoint_i.index, waypoint_i.count, wp_status, wp_name, wp_info,
    waypoint_i.latitude, waypoint_i.longitude, wp_bear, wp_dist, wp_cdev, wp_eet, wp_eta
  };
  wire logic [TSF_WP_BITS-1:0] wp_sel = wp_empty ?
    {waypoint_i.index, 8'h00, {(TSF_WP_BITS-16){1'b0}}} : wp_full;
  wire logic [TSF_MAX_BITS-1:0] wp_block = {wp_sel, {(TSF_MAX_BITS-TSF_WP_BITS){1'b0}}};

  //////////////////////////////////////////////////////////////////////////////
  // Register decode

  tsf_state_t        state_q;
  tsf_state_t        state_d;
  logic [1:0]        pend_q;
  logic [1:0]        pend_d;
  logic [15:0]       frames_q;
  logic [6:0]        left_q;
  logic [6:0]        len_q;
  logic [6:0]        id_q;
  logic [TSF_MAX_BITS-1:0] shift_q;
  logic [31:0]       rdata_q;

  wire logic         wr_ctrl   = reg_we_i && (reg_addr_i == TSF_REG_CTRL);
  wire logic         rd_ctrl   = reg_addr_i == TSF_REG_CTRL;
  wire logic         rd_status = reg_addr_i == TSF_REG_STATUS;
  wire logic         rd_frames = reg_addr_i == TSF_REG_FRAMES;
  wire logic         busy      = (state_q == TSF_ST_SEND);

  // Unmapped addresses read as zero
  wire logic [31:0]  rd_mux =
    rd_ctrl   ? {30'h0, pend_q} :
    rd_status ? {16'h0, 1'b0, left_q, 1'b0, id_q} | {31'h0, busy} << 31 :
    rd_frames ? {16'h0, frames_q} : 32'h0;

  //////////////////////////////////////////////////////////////////////////////
  // Sequencing

  // Beacon frames go before waypoint frames when both are pending
  wire logic         start_bc = !busy && pend_q[TSF_CTRL_BEACON];
  wire logic         start_wp = !busy && !pend_q[TSF_CTRL_BEACON] &&
                                pend_q[TSF_CTRL_WAYPOINT];
  wire logic         take     = busy && tx_ready_i;
  wire logic         done     = take && (left_q == 7'h01);

  // A request written in the cycle it is taken stays pending: set wins
  always_comb
  begin
    pend_d = pend_q;
    if (start_bc)
      pend_d[TSF_CTRL_BEACON] = 1'b0;
    if (start_wp)
      pend_d[TSF_CTRL_WAYPOINT] = 1'b0;
    if (wr_ctrl)
      pend_d = pend_d | reg_wdata_i[1:0];
  end

  // Idle until a request, send until the last byte is accepted
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      TSF_ST_IDLE:
        if (start_bc || start_wp)
          state_d = TSF_ST_SEND;
      TSF_ST_SEND:
        if (done)
          state_d = TSF_ST_IDLE;
    endcase
  end

  // Control registers
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state_q  <= TSF_ST_IDLE;
      pend_q   <= TSF_CTRL_RESET;
      frames_q <= TSF_FRAMES_RESET;
      rdata_q  <= 32'h0;
    end
    else
    begin
      state_q  <= state_d;
      pend_q   <= pend_d;
      frames_q <= done ? frames_q + 16'h0001 : frames_q;
      rdata_q  <= reg_re_i ? rd_mux : 32'h0;
    end
  end

  // Snapshot of the record, shifted out one byte per accepted beat.
  // Latching at start keeps a frame coherent while the source updates.
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      shift_q <= '0;
      left_q  <= 7'h00;
      len_q   <= 7'h00;
      id_q    <= 7'h00;
    end
    else if (start_bc)
    begin
      shift_q <= bc_block;
      left_q  <= TSF_BEACON_LEN;
      len_q   <= TSF_BEACON_LEN;
      id_q    <= TSF_BEACON_ID;
    end
    else if (start_wp)
    begin
      shift_q <= wp_block;
      left_q  <= TSF_WAYPOINT_LEN;
      len_q   <= TSF_WAYPOINT_LEN;
      id_q    <= TSF_WAYPOINT_ID;
    end
    else if (take)
    begin
      shift_q <= {shift_q[TSF_MAX_BITS-9:0], 8'h00};
      left_q  <= left_q - 7'h01;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign reg_rdata_o      = rdata_q;
  assign tx_valid_o       = busy;
  assign tx_o.frame_id    = id_q;
  assign tx_o.data        = shift_q[TSF_MAX_BITS-1 -: 8];
  assign tx_o.first       = busy && (left_q == len_q);
  assign tx_o.last        = busy && (left_q == 7'h01);

endmodule

`default_nettype wire

// File: src/tsf_pkg.sv
package tsf_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Frame identities and value block sizes
  localparam logic [6:0]  TSF_BEACON_ID     = 7'h00;
  localparam logic [6:0]  TSF_WAYPOINT_ID   = 7'h01;
  localparam logic [6:0]  TSF_BEACON_LEN    = 7'h45;   // 69 bytes
  localparam logic [6:0]  TSF_WAYPOINT_LEN  = 7'h35;   // 53 bytes
  localparam int          TSF_MAX_BITS      = 552;     // 69 bytes of 8 bits
  localparam int          TSF_WP_BITS       = 424;     // 53 bytes of 8 bits

  //////////////////////////////////////////////////////////////////////////////
  // Register offsets and control fields
  localparam logic [7:0]  TSF_REG_CTRL      = 8'h00;
  localparam logic [7:0]  TSF_REG_STATUS    = 8'h04;
  localparam logic [7:0]  TSF_REG_FRAMES    = 8'h08;
  localparam int          TSF_CTRL_BEACON   = 0;
  localparam int          TSF_CTRL_WAYPOINT = 1;
  localparam logic [1:0]  TSF_CTRL_RESET    = 2'h0;
  localparam logic [15:0] TSF_FRAMES_RESET  = 16'h0000;

  //////////////////////////////////////////////////////////////////////////////
  // Field codes and limits
  localparam logic [7:0]  TSF_INV8          = 8'hFF;
  localparam logic [15:0] TSF_INV16         = 16'hFFFF;
  localparam logic [3:0]  TSF_INV4          = 4'hF;
  localparam logic [31:0] TSF_SHORT_FILL    = 32'hFFFFFFFF;
  localparam logic signed [15:0] TSF_FREQ_MIN = -16'sd30000;
  localparam logic signed [15:0] TSF_FREQ_MAX = 16'sd31000;
  localparam logic signed [15:0] TSF_DBM_MIN  = -16'sd150;
  localparam logic signed [15:0] TSF_DBM_MAX  = 16'sd104;
  localparam logic [15:0] TSF_DBM_BIAS      = 16'h0096;  // 150
  localparam logic [15:0] TSF_ANGLE_MAX     = 16'h0E0F;  // 3599
  localparam logic [15:0] TSF_DIST_MAX      = 16'h270F;  // 9999
  localparam logic [15:0] TSF_COUNTRY_MAX   = 16'h03E7;  // 999
  localparam logic [15:0] TSF_SERIAL_MAX    = 16'h3FFF;  // 16383
  localparam logic [3:0]  TSF_CAT_LAST      = 4'h4;      // test beacon
  localparam logic [3:0]  TSF_PROTO_LAST    = 4'h3;      // user location

  //////////////////////////////////////////////////////////////////////////////
  // Records
  typedef struct packed {
    logic [7:0] year;
    logic [7:0] month;
    logic [7:0] day;
    logic [7:0] hour;
    logic [7:0] minute;
    logic [7:0] second;
  } tsf_date_t;

  typedef struct packed {
    logic [7:0] hour;
    logic [7:0] minute;
    logic [7:0] second;
  } tsf_hms_t;

  typedef struct packed {
    logic [7:0]         index;
    logic [7:0]         count;
    logic               self_test;
    logic               manual_offset;
    logic               auto_offset;
    logic               pdf2_valid;
    logic               dist_nm;
    logic               pos_valid;
    logic [127:0]       message;      // bit 17 of the message at bit 127
    logic               short_msg;
    logic [59:0]        beacon_hex_identifier;
    tsf_date_t          first_seen;
    tsf_date_t          last_seen;
    logic [31:0]        latitude;     // IEEE single precision
    logic [31:0]        longitude;
    logic signed [15:0] freq_offset;
    logic signed [15:0] dbm;
    logic               dbm_valid;
    logic [15:0]        msg_counter;
    logic [15:0]        bearing;
    logic [15:0]        distance;
    logic [15:0]        course_deviation;
    tsf_hms_t           elapsed_time_to_target;
    tsf_hms_t           arrival_time_at_target;
    logic [15:0]        country;
    logic [3:0]         category;
    logic [3:0]         protocol;
    logic [15:0]        serial;
  } tsf_beacon_t;

  typedef struct packed {
    logic [7:0]   index;
    logic [7:0]   count;
    logic         dist_nm;
    logic         pos_valid;
    logic [79:0]  name;               // first character in bits 79:72
    logic [159:0] info;
    logic [31:0]  latitude;
    logic [31:0]  longitude;
    logic [15:0]  bearing;
    logic [15:0]  distance;
    logic [15:0]  course_deviation;
    tsf_hms_t     elapsed_time_to_target;
    tsf_hms_t     arrival_time_at_target;
  } tsf_waypoint_t;

  typedef struct packed {
    logic [6:0] frame_id;
    logic       first;
    logic       last;
    logic [7:0] data;
  } tsf_byte_t;

  typedef enum logic [0:0] {
    TSF_ST_IDLE = 1'b0,
    TSF_ST_SEND = 1'b1
  } tsf_state_t;

endpackage

// File: verification/target_status_frame_builder_tb.sv
`timescale 1ns/1ps
`default_nettype none

module target_status_frame_builder_tb
  import tsf_pkg::*;
;
  logic          clk;
  logic          rstn;
  logic [7:0]    addr;
  logic [31:0]   wdata;
  logic          we, re;
  logic [31:0]   rdata;
  tsf_beacon_t   bcn;
  tsf_waypoint_t wpt;
  logic          valid;
  logic          ready;
  logic          stall;
  tsf_byte_t     txb;
  logic [15:0]   exp_q[$];
  int            n_fail;
  int            checks_done;
  int            cyc, frames;

  tsf_frame_builder tsf_frame_builder_inst (.ref_clk_i(clk), .resetn_i(rstn),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_we_i(we), .reg_re_i(re),
    .reg_rdata_o(rdata), .beacon_i(bcn), .waypoint_i(wpt), .tx_valid_o(valid),
    .tx_ready_i(ready), .tx_o(txb));
  tsf_sink_model tsf_sink_model_inst (.ref_clk_i(clk), .resetn_i(rstn), .stall_i(stall),
    .tx_valid_o(valid), .tx_o(txb), .tx_ready_i(ready));

  //////////////////////////////////////////////////////////////////////////////
  // Field limits: out of range turns into the invalid code
  function automatic logic [7:0] l8(input logic [7:0] v, lo, mx);
    return (v < lo || v > mx) ? 8'hFF : v;
  endfunction
  function automatic logic [15:0] l16(input logic [15:0] v, input logic [15:0] mx);
    return (v > mx) ? 16'hFFFF : v;
  endfunction
  function automatic logic [3:0] l4(input logic [3:0] v, input logic [3:0] mx);
    return (v > mx) ? 4'hF : v;
  endfunction
  function automatic logic [23:0] hms(input tsf_hms_t t);
    return {l8(t.hour, 8'd0, 8'd23), l8(t.minute, 8'd0, 8'd59), l8(t.second, 8'd0, 8'd59)};
  endfunction
  function automatic logic [47:0] dt(input tsf_date_t t);
    return {l8(t.year, 8'd0, 8'd99), l8(t.month, 8'd1, 8'd12), l8(t.day, 8'd1, 8'd31),
            l8(t.hour, 8'd0, 8'd23), l8(t.minute, 8'd0, 8'd59), l8(t.second, 8'd0, 8'd59)};
  endfunction
  // Text outside the allowed set becomes a space; zero padding stays
  function automatic logic [7:0] ch(input logic [7:0] c);
    return (c inside {8'h00, 8'h20, 8'h2D, 8'h2E, 8'h2F, [8'h30:8'h39], [8'h41:8'h5A]})
      ? c : 8'h20;
  endfunction

  task automatic push_bcn(input tsf_beacon_t b);
    logic [551:0] v;
    logic [127:0] m;
    logic signed [15:0] f;
    logic [7:0] d;
    m = b.short_msg ? {b.message[127:32], 32'hFFFFFFFF} : b.message;
    f = (b.freq_offset < -16'sd30000) ? -16'sd30000 :
        (b.freq_offset > 16'sd31000) ? 16'sd31000 : b.freq_offset;
    d = (b.dbm_valid && b.dbm >= -16'sd150 && b.dbm <= 16'sd104) ? 8'(b.dbm + 16'sd150) : 8'hFF;
    v = {b.index, b.count, 2'b00, b.self_test, b.manual_offset, b.auto_offset, b.pdf2_valid,
         b.dist_nm, b.pos_valid, m, 4'h0, b.beacon_hex_identifier, dt(b.first_seen),
         dt(b.last_seen), b.latitude, b.longitude, f, d, b.msg_counter,
         l16(b.bearing, 16'd3599), l16(b.distance, 16'd9999), l16(b.course_deviation, 16'd3599),
         hms(b.elapsed_time_to_target), hms(b.arrival_time_at_target),
         l16(b.country, 16'd999), l4(b.category, 4'h4), l4(b.protocol, 4'h3),
         ((b.serial == 16'h0000) ? 16'hFFFF : l16(b.serial, 16'd16383))};
    if (b.count == 8'h00)
      v[535:0] = '0;
    for (int i = 0; i < 69; i++)
      exp_q.push_back({8'h00, v[551 - 8 * i -: 8]});
    frames++;
  endtask

  task automatic push_wpt(input tsf_waypoint_t w);
    logic [423:0] v;
    for (int i = 0; i < 10; i++)
      w.name[8 * i +: 8] = ch(w.name[8 * i +: 8]);
    for (int i = 0; i < 20; i++)
      w.info[8 * i +: 8] = ch(w.info[8 * i +: 8]);
    v = {w.index, w.count, 6'h00, w.dist_nm, w.pos_valid, w.name, w.info, w.latitude,
         w.longitude, l16(w.bearing, 16'd3599), l16(w.distance, 16'd9999),
         l16(w.course_deviation, 16'd3599), hms(w.elapsed_time_to_target),
         hms(w.arrival_time_at_target)};
    if (w.count == 8'h00)
      v[407:0] = '0;
    for (int i = 0; i < 53; i++)
      exp_q.push_back({8'h01, v[423 - 8 * i -: 8]});
    frames++;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    we    <= 1'b1;
    @(posedge clk);
    we    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    re   <= 1'b1;
    @(posedge clk);
    re   <= 1'b0;
    #1 d = rdata;
  endtask

  // Request frames, collect them at the sink and compare byte by byte
  task automatic run(input logic [1:0] req, input string nm);
    logic [31:0] d;
    tsf_sink_model_inst.got.delete();
    wr(TSF_REG_CTRL, {30'h0, req});
    for (int i = 0; i < 3000 && tsf_sink_model_inst.got.size() < exp_q.size(); i++)
      @(posedge clk);
    repeat (8) @(posedge clk);
    check("frame length", tsf_sink_model_inst.got.size(), exp_q.size());
    for (int i = 0; i < exp_q.size() && i < tsf_sink_model_inst.got.size(); i++)
      check("frame byte", tsf_sink_model_inst.got[i], exp_q[i]);
    rd(TSF_REG_FRAMES, d);
    check("frames done", d, frames);
    exp_q.delete();
    $display("test %s done", nm);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      wrap_up();
    end
  end

  initial
  begin
    logic [31:0] d;
    rstn = 1'b0; addr = 8'h00; wdata = 32'h0; we = 1'b0; re = 1'b0; stall = 1'b0;
    bcn = '0; wpt = '0; n_fail = 0; checks_done = 0; cyc = 0; frames = 0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    rd(TSF_REG_FRAMES, d);
    check("frames reset", d, 32'h0);
    rd(8'h0C, d);
    check("unmapped read", d, 32'h0);
    // Every limited field in range, at its upper or lower bound
    bcn.index = 8'h01; bcn.count = 8'h03; bcn.dist_nm = 1'b1; bcn.pos_valid = 1'b1;
    bcn.self_test = 1'b1; bcn.message = {4{32'hA55A0FF0}};
    bcn.beacon_hex_identifier = 60'h0123456789ABCDE;
    bcn.first_seen = {8'h63, 8'h0C, 8'h1F, 8'h17, 8'h3B, 8'h3B};
    bcn.last_seen = {8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00};
    bcn.latitude = 32'hC2B40000; bcn.longitude = 32'h43340000;
    bcn.freq_offset = -16'sd30000; bcn.dbm = 16'sd104; bcn.dbm_valid = 1'b1;
    bcn.msg_counter = 16'hFFFE; bcn.bearing = 16'd3599; bcn.distance = 16'd9999;
    bcn.elapsed_time_to_target = {8'h17, 8'h3B, 8'h3B}; bcn.country = 16'd999;
    bcn.category = 4'h4; bcn.protocol = 4'h3; bcn.serial = 16'd16383;
    push_bcn(bcn);
    run(2'b01, "beacon in range");
    // One step past a bound in every limited field but elapsed time and dBm (flagged invalid instead), with the sink stalling
    stall <= 1'b1;
    bcn.short_msg = 1'b1; bcn.first_seen.year = 8'h64; bcn.last_seen.hour = 8'h18;
    bcn.freq_offset = 16'sd31001; bcn.dbm_valid = 1'b0; bcn.bearing = 16'd3600;
    bcn.distance = 16'd10000; bcn.course_deviation = 16'd3600; bcn.country = 16'd1000;
    bcn.arrival_time_at_target = {8'h00, 8'h3C, 8'h00}; bcn.category = 4'h5;
    bcn.protocol = 4'h4; bcn.serial = 16'd16384; bcn.first_seen.month = 8'h00;
    push_bcn(bcn);
    run(2'b01, "beacon invalid");
    // Waypoint with forbidden characters and an invalid course
    wpt.index = 8'h00; wpt.count = 8'h01; wpt.dist_nm = 1'b1; wpt.pos_valid = 1'b1;
    wpt.name = {"AB-9./ a", 16'h0000}; wpt.info = {"X#Y", 136'h0};
    wpt.latitude = 32'h42B40000; wpt.longitude = 32'hC3340000; wpt.bearing = 16'd100;
    wpt.distance = 16'd9999; wpt.course_deviation = 16'd3600;
    wpt.arrival_time_at_target = {8'h18, 8'h00, 8'h00};
    push_wpt(wpt);
    run(2'b10, "waypoint");
    // Both at once: beacon first, then waypoint, both empty
    bcn.count = 8'h00; wpt.count = 8'h00;
    push_bcn(bcn);
    push_wpt(wpt);
    run(2'b11, "empty pair");
    // Frame counter is read only
    wr(TSF_REG_FRAMES, 32'h0000_1234);
    rd(TSF_REG_FRAMES, d);
    check("frames kept", d, frames);
    rd(TSF_REG_STATUS, d);
    check("status idle", d, 32'h0000_0001);
    rd(TSF_REG_CTRL, d);
    check("nothing pending", d, 32'h0);
    $display("test read only done");
    wrap_up();
  end

endmodule

`default_nettype wire

// File: verification/tsf_frame_builder_assertions.sv
`timescale 1ns/1ps
`default_nettype none

module tsf_frame_builder_chk
  import tsf_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        resetn_i,
  // Register port
  input  wire logic        reg_re_i,
  input  wire logic [31:0] reg_rdata_o,
  // Byte stream
  input  wire logic        tx_valid_o,
  input  wire logic        tx_ready_i,
  input  wire tsf_byte_t   tx_o
);

  logic [6:0] cnt_q;
  logic       take;

  // Byte position inside the frame, cleared after the closing byte
  assign take  = tx_valid_o && tx_ready_i;
  always_ff @(posedge ref_clk_i or negedge resetn_i)
    if (!resetn_i)
      cnt_q <= 7'h00;
    else
      cnt_q <= take ? (tx_o.last ? 7'h00 : cnt_q + 7'h01) : cnt_q;

  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);

  // Frame, position and read data checks
  chk_frame_id: assert property (tx_valid_o |-> tx_o.frame_id inside {7'h00, 7'h01})
    else $error("frame id out of set");
  chk_frame_len: assert property (tx_valid_o && tx_o.last |->
    cnt_q == ((tx_o.frame_id == 7'h00) ? 7'd68 : 7'd52))
    else $error("frame length wrong");
  chk_first_pos: assert property (tx_valid_o |-> tx_o.first == (cnt_q == 7'h00))
    else $error("first flag misplaced");
  chk_start_first: assert property ($rose(tx_valid_o) |-> tx_o.first)
    else $error("frame starts mid block");
  chk_byte_hold: assert property (tx_valid_o && !tx_ready_i |=>
    tx_valid_o && $stable(tx_o))
    else $error("byte changed while stalled");
  chk_end_gap: assert property (take && tx_o.last |=> !tx_valid_o)
    else $error("no gap after frame");
  chk_status_zero: assert property (tx_valid_o && cnt_q == 7'd2 |->
    tx_o.data[7:6] == 2'b00 && (tx_o.frame_id == 7'h00 || tx_o.data[5:2] == 4'h0))
    else $error("status spare bits set");
  chk_hex_nibble: assert property (tx_valid_o && tx_o.frame_id == 7'h00 &&
    cnt_q == 7'd19 |-> tx_o.data[7:4] == 4'h0)
    else $error("identifier top nibble set");
  chk_type_codes: assert property (tx_valid_o && tx_o.frame_id == 7'h00 &&
    cnt_q == 7'd66 |-> (tx_o.data[7:4] <= 4'h4 || tx_o.data[7:4] == 4'hF) &&
    (tx_o.data[3:0] <= 4'h3 || tx_o.data[3:0] == 4'hF))
    else $error("unused type code sent");
  chk_rdata_idle: assert property (!$past(reg_re_i) |-> reg_rdata_o == 32'h0)
    else $error("read data outside read slot");

  // Main scenarios
  cov_beacon: cover property (take && tx_o.last && tx_o.frame_id == 7'h00);
  cov_waypoint: cover property (take && tx_o.last && tx_o.frame_id == 7'h01);
  cov_stall: cover property (tx_valid_o && !tx_ready_i);

endmodule

bind tsf_frame_builder tsf_frame_builder_chk tsf_frame_builder_chk_inst (
  .ref_clk_i   (ref_clk_i),
  .resetn_i    (resetn_i),
  .reg_re_i    (reg_re_i),
  .reg_rdata_o (reg_rdata_o),
  .tx_valid_o  (tx_valid_o),
  .tx_ready_i  (tx_ready_i),
  .tx_o        (tx_o)
);

`default_nettype wire

// File: verification/tsf_sink_model.sv
`timescale 1ns/1ps
`default_nettype none

// Packet layer stand-in: accepts bytes, stalls on request
module tsf_sink_model
  import tsf_pkg::*;
(
  input  wire logic ref_clk_i,
  input  wire logic resetn_i,
  input  wire logic stall_i,
  input  wire logic tx_valid_o,
  input  wire tsf_byte_t tx_o,
  output var logic tx_ready_i
);

  logic [15:0] got[$];
  logic [1:0]  ph_q;

  // Ready drops one cycle in four when stalling, to exercise holding
  always @(posedge ref_clk_i or negedge resetn_i)
    if (!resetn_i)
    begin
      ph_q       <= 2'h0;
      tx_ready_i <= 1'b0;
    end
    else
    begin
      ph_q       <= ph_q + 2'h1;
      tx_ready_i <= !stall_i || (ph_q != 2'h0);
    end

  always @(posedge ref_clk_i)
    if (resetn_i && tx_valid_o && tx_ready_i)
      got.push_back({1'b0, tx_o.frame_id, tx_o.data});

endmodule

`default_nettype wire
